// [lbs_pkg.sv]
package lbs_pkg;
    // register offsets
    localparam logic [7:0] OFS_BOOST_CFG  = 8'h05;
    localparam logic [7:0] OFS_NEG_GATE   = 8'h06;
    localparam logic [7:0] OFS_LOGIC_RAIL = 8'h07;
    localparam logic [7:0] OFS_RST_THRESH = 8'h08;
    localparam logic [7:0] OFS_RST_DELAY  = 8'h09;
    localparam logic [7:0] OFS_SHAPE_DLY  = 8'h0a;
    localparam logic [7:0] OFS_COM_HOT    = 8'h0b;
    localparam logic [7:0] OFS_COM_COLD   = 8'h0c;

    // writable bit masks, reserved bits clear
    localparam logic [7:0] MSK_BOOST_CFG  = 8'h1f;
    localparam logic [7:0] MSK_NEG_GATE   = 8'h3f;
    localparam logic [7:0] MSK_LOGIC_RAIL = 8'h0f;
    localparam logic [7:0] MSK_RST_THRESH = 8'h07;
    localparam logic [7:0] MSK_RST_DELAY  = 8'h0f;
    localparam logic [7:0] MSK_SHAPE_DLY  = 8'h03;
    localparam logic [7:0] MSK_COM        = 8'hff;

    // field positions in the boost configuration register
    localparam int SLEW_LSB = 0;
    localparam int SS_LSB   = 2;
    localparam int FREQ_BIT = 4;

    // lowest valid codes
    localparam logic [5:0] NEG_GATE_MIN = 6'h15;
    localparam logic [7:0] COM_MIN      = 8'h28;

    // reset values
    localparam logic [7:0] RST_VAL = 8'h00;

    // timing units
    localparam int SS_STEP_MS    = 4;
    localparam int RST_STEP_MS   = 2;
    localparam int SHAPE_STEP_MS = 20;

    typedef struct packed {
        logic [7:0] boost_cfg;
        logic [7:0] neg_gate;
        logic [7:0] logic_rail;
        logic [7:0] rst_thresh;
        logic [7:0] rst_delay;
        logic [7:0] shape_dly;
        logic [7:0] com_hot;
        logic [7:0] com_cold;
        logic [7:0] rdata;
    } lbs_state_t;
endpackage

// [lbs_dec_if.sv]
`timescale 1ns/100ps
// register fields passed from the bank to the field decoder, decoded fields passed back
interface lbs_dec_if;
    logic [7:0] boost_cfg;
    logic [7:0] neg_gate;
    logic [7:0] com_hot;
    logic [7:0] com_cold;
    logic       range_sel;
    logic [1:0] slew;
    logic [4:0] ss_ms;
    logic       freq_high;
    logic       neg_gate_ok;
    logic       com_hot_ok;
    logic       com_cold_ok;
    modport bank (output boost_cfg, neg_gate, com_hot, com_cold, range_sel,
                  input slew, ss_ms, freq_high, neg_gate_ok, com_hot_ok, com_cold_ok);
    modport dec  (input boost_cfg, neg_gate, com_hot, com_cold, range_sel,
                  output slew, ss_ms, freq_high, neg_gate_ok, com_hot_ok, com_cold_ok);
endinterface

// [lbs_field_dec.sv]
`timescale 1ns/100ps
module lbs_field_dec
(
    lbs_dec_if.dec d
);
    // boost configuration fields
    always_comb
    begin
        d.slew      = d.boost_cfg[lbs_pkg::SLEW_LSB +: 2];
        d.ss_ms     = 5'(({3'h0, d.boost_cfg[lbs_pkg::SS_LSB +: 2]} + 5'h01)
                      * 5'(lbs_pkg::SS_STEP_MS));
        d.freq_high = d.boost_cfg[lbs_pkg::FREQ_BIT];
    end

    // validity of coded levels; range select does not change the valid span
    always_comb
    begin
        d.neg_gate_ok = d.neg_gate[5:0] >= lbs_pkg::NEG_GATE_MIN;
        d.com_hot_ok  = d.com_hot  >= lbs_pkg::COM_MIN;
        d.com_cold_ok = d.com_cold >= lbs_pkg::COM_MIN;
    end
endmodule // lbs_field_dec

// [lbs_bias_regs.sv]
`timescale 1ns/100ps
// Function
// - boost config bits 1-0 select switch falling slew, 00 slowest.
// - boost config bits 3-2 give soft start 4, 8, 12 or 16 ms.
// - boost config bit 4 selects 400 kHz (0) or 800 kHz (1).
// - reserved upper bits drop writes and read back zero.
// - negative gate rail register at 06h, six-bit field bits 5-0.
// - negative gate codes below 010101 invalid; -3.8 V down to -8.0 V.
// - logic rail at 07h, bits 3-0, 1.5 V plus 0.1 V per code.
// - reset threshold at 08h, three bits, 1.2 V plus 0.2 V steps.
// - shaping delay at 0Ah, bits 1-0, 0 to 60 ms in 20 ms.
// - hot common level at 0Bh, eight bits, hot or fixed setting.
// - common codes to 00100111 invalid; 20 mV steps in either range.
// - range select bit picks full or split supply common range.
// - cold common level at 0Ch, read/write, used cold with compensation.
// - logic rail reads back stored field, upper nibble zero.
module lbs_bias_regs
(
    // clock, reset, enable
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    input  wire logic       i_ce,
    // register port from the serial slave, plus common range, fixed setting and temperature inputs
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_rd,
    input  wire logic       i_com_range_sel,
    input  wire logic       i_com_fixed_setting,
    input  wire logic       i_temp_cold,
    output logic      [7:0] o_rdata,
    output logic            o_hit,
    // decoded settings to the analog side
    output logic      [1:0] o_gate_high_switch_slew,
    output logic      [4:0] o_gate_high_soft_start_ms,
    output logic            o_gate_high_switch_frequency,
    output logic      [5:0] o_neg_gate_code,
    output logic            o_neg_gate_valid,
    output logic      [3:0] o_logic_rail_code,
    output logic      [2:0] o_reset_threshold_code,
    output logic      [4:0] o_reset_delay_ms,
    output logic      [5:0] o_shaping_delay_ms,
    output logic      [7:0] o_com_level_code,
    output logic            o_com_level_valid,
    output logic            o_com_split_range
);
    lbs_pkg::lbs_state_t s_q;
    lbs_pkg::lbs_state_t s_d;
    lbs_dec_if           dec_if ();

    // address decode to write masks, used by the write path only
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        unique case (a)
            lbs_pkg::OFS_BOOST_CFG:  mask_of = lbs_pkg::MSK_BOOST_CFG;
            lbs_pkg::OFS_NEG_GATE:   mask_of = lbs_pkg::MSK_NEG_GATE;
            lbs_pkg::OFS_LOGIC_RAIL: mask_of = lbs_pkg::MSK_LOGIC_RAIL;
            lbs_pkg::OFS_RST_THRESH: mask_of = lbs_pkg::MSK_RST_THRESH;
            lbs_pkg::OFS_RST_DELAY:  mask_of = lbs_pkg::MSK_RST_DELAY;
            lbs_pkg::OFS_SHAPE_DLY:  mask_of = lbs_pkg::MSK_SHAPE_DLY;
            lbs_pkg::OFS_COM_HOT:    mask_of = lbs_pkg::MSK_COM;
            lbs_pkg::OFS_COM_COLD:   mask_of = lbs_pkg::MSK_COM;
            default:                 mask_of = 8'h00;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a >= lbs_pkg::OFS_BOOST_CFG) && (a <= lbs_pkg::OFS_COM_COLD);
    endfunction

    // next state: masked writes and registered read data
    always_comb
    begin
        logic [7:0] wv;
        wv   = i_wdata & mask_of(i_addr);
        s_d  = s_q;
        if (i_wr)
        begin
            unique case (i_addr)
                lbs_pkg::OFS_BOOST_CFG:  s_d.boost_cfg  = wv;
                lbs_pkg::OFS_NEG_GATE:   s_d.neg_gate   = wv;
                lbs_pkg::OFS_LOGIC_RAIL: s_d.logic_rail = wv;
                lbs_pkg::OFS_RST_THRESH: s_d.rst_thresh = wv;
                lbs_pkg::OFS_RST_DELAY:  s_d.rst_delay  = wv;
                lbs_pkg::OFS_SHAPE_DLY:  s_d.shape_dly  = wv;
                lbs_pkg::OFS_COM_HOT:    s_d.com_hot    = wv;
                lbs_pkg::OFS_COM_COLD:   s_d.com_cold   = wv;
                default:                 s_d.rdata      = s_q.rdata;
            endcase
        end
        // illegal codes are kept as written; the analog side sees the flag
        if (i_rd)
        begin
            unique case (i_addr)
                lbs_pkg::OFS_BOOST_CFG:  s_d.rdata = s_q.boost_cfg;
                lbs_pkg::OFS_NEG_GATE:   s_d.rdata = s_q.neg_gate;
                lbs_pkg::OFS_LOGIC_RAIL: s_d.rdata = s_q.logic_rail;
                lbs_pkg::OFS_RST_THRESH: s_d.rdata = s_q.rst_thresh;
                lbs_pkg::OFS_RST_DELAY:  s_d.rdata = s_q.rst_delay;
                lbs_pkg::OFS_SHAPE_DLY:  s_d.rdata = s_q.shape_dly;
                lbs_pkg::OFS_COM_HOT:    s_d.rdata = s_q.com_hot;
                lbs_pkg::OFS_COM_COLD:   s_d.rdata = s_q.com_cold;
                default:                 s_d.rdata = 8'h00;          // unmapped reads zero
            endcase
        end
    end

    // state register; enable freezes everything but a reset
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            s_q <= '{default: lbs_pkg::RST_VAL};
        end
        else if (i_ce)
        begin
            s_q <= s_d;
        end
    end

    // field decoding lives in a leaf
    assign dec_if.boost_cfg = s_q.boost_cfg;
    assign dec_if.neg_gate  = s_q.neg_gate;
    assign dec_if.com_hot   = s_q.com_hot;
    assign dec_if.com_cold  = s_q.com_cold;
    assign dec_if.range_sel = i_com_range_sel;

    lbs_field_dec u_dec
    (
        .d (dec_if.dec)
    );

    // read data and hit flag
    assign o_rdata = s_q.rdata;
    assign o_hit   = is_mapped(i_addr);

    // settings straight from flip-flops
    assign o_gate_high_switch_slew      = dec_if.slew;
    assign o_gate_high_soft_start_ms    = dec_if.ss_ms;
    assign o_gate_high_switch_frequency = dec_if.freq_high;
    assign o_neg_gate_code              = s_q.neg_gate[5:0];
    assign o_neg_gate_valid             = dec_if.neg_gate_ok;
    assign o_logic_rail_code            = s_q.logic_rail[3:0];
    assign o_reset_threshold_code       = s_q.rst_thresh[2:0];
    assign o_reset_delay_ms             = 5'({1'b0, s_q.rst_delay[3:0]}
                                          * 5'(lbs_pkg::RST_STEP_MS));
    assign o_shaping_delay_ms           = 6'({4'h0, s_q.shape_dly[1:0]}
                                          * 6'(lbs_pkg::SHAPE_STEP_MS));

    // hot code applies always in fixed mode, cold code only when cold
    always_comb
    begin
        if (!i_com_fixed_setting && i_temp_cold)
        begin
            o_com_level_code  = s_q.com_cold;
            o_com_level_valid = dec_if.com_cold_ok;
        end
        else
        begin
            o_com_level_code  = s_q.com_hot;
            o_com_level_valid = dec_if.com_hot_ok;
        end
    end
    assign o_com_split_range = dec_if.range_sel;
endmodule // lbs_bias_regs

// [lbs_host_model.sv]
`timescale 1ns/100ps
// host side of the register port: one strobe per access, a gap cycle after it
module lbs_host_model
(
    // clock and answer
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    // register port
    output logic      [7:0] o_addr  = 8'h00,
    output logic            o_wr    = 1'b0,
    output logic      [7:0] o_wdata = 8'h00,
    output logic            o_rd    = 1'b0
);
    // write; data flips once released so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk_sys);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        // let the register update settle before the caller looks at outputs
        #1;
    endtask
    // read; data is registered at the read edge and taken just after it
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk_sys);
        o_rd   <= 1'b0;
        #1 q = i_rdata;
    endtask
endmodule // lbs_host_model

// [lbs_bias_regs_properties.sv]
`timescale 1ns/100ps
module lbs_bias_regs_props
(
    // watched ports
    input wire logic       i_clk_sys,
    input wire logic       i_srst,
    input wire logic       i_ce,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_rd,
    input wire logic       i_com_range_sel,
    input wire logic [7:0] o_rdata,
    input wire logic       o_hit,
    input wire logic [1:0] o_gate_high_switch_slew,
    input wire logic [4:0] o_gate_high_soft_start_ms,
    input wire logic       o_gate_high_switch_frequency,
    input wire logic [5:0] o_neg_gate_code,
    input wire logic       o_neg_gate_valid,
    input wire logic [4:0] o_reset_delay_ms,
    input wire logic [5:0] o_shaping_delay_ms,
    input wire logic [7:0] o_com_level_code,
    input wire logic       o_com_level_valid,
    input wire logic       o_com_split_range
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // a write is only taken with the enable high
    logic wv;
    assign wv = i_ce && i_wr;
    property p_slew; wv && i_addr == 8'h05 |=> o_gate_high_switch_slew == $past(i_wdata[1:0]); endproperty
    a_slew: assert property (p_slew) else $error("slew field wrong");
    property p_ss; wv && i_addr == 8'h05 |=> o_gate_high_soft_start_ms == 5'(4 * ($past(i_wdata[3:2]) + 1)); endproperty
    a_ss: assert property (p_ss) else $error("soft start wrong");
    property p_freq; wv && i_addr == 8'h05 |=> o_gate_high_switch_frequency == $past(i_wdata[4]); endproperty
    a_freq: assert property (p_freq) else $error("frequency bit wrong");
    property p_unmap; i_ce && i_rd && !o_hit |=> o_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_neg; wv && i_addr == 8'h06 |=> o_neg_gate_code == $past(i_wdata[5:0]) && o_neg_gate_valid == ($past(i_wdata[5:0]) >= 6'h15); endproperty
    a_neg: assert property (p_neg) else $error("negative rail wrong");
    property p_rdel; wv && i_addr == 8'h09 |=> o_reset_delay_ms == 5'(2 * $past(i_wdata[3:0])); endproperty
    a_rdel: assert property (p_rdel) else $error("reset delay wrong");
    property p_shape; wv && i_addr == 8'h0a |=> o_shaping_delay_ms == 6'(20 * $past(i_wdata[1:0])); endproperty
    a_shape: assert property (p_shape) else $error("shaping delay wrong");
    property p_cvld; o_com_level_valid == (o_com_level_code >= 8'h28); endproperty
    a_cvld: assert property (p_cvld) else $error("common valid flag wrong");
    property p_split; o_com_split_range == i_com_range_sel; endproperty
    a_split: assert property (p_split) else $error("range select wrong");
    c_boost: cover property (wv && i_addr == 8'h05);
    c_unmap: cover property (i_ce && i_rd && !o_hit);
    c_inval: cover property (!o_neg_gate_valid ##1 o_neg_gate_valid);
endmodule // lbs_bias_regs_props
bind lbs_bias_regs lbs_bias_regs_props i_props (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata), .i_rd(i_rd), .i_com_range_sel(i_com_range_sel),
    .o_rdata(o_rdata), .o_hit(o_hit), .o_gate_high_switch_slew(o_gate_high_switch_slew),
    .o_gate_high_soft_start_ms(o_gate_high_soft_start_ms), .o_neg_gate_code(o_neg_gate_code),
    .o_gate_high_switch_frequency(o_gate_high_switch_frequency), .o_neg_gate_valid(o_neg_gate_valid),
    .o_reset_delay_ms(o_reset_delay_ms), .o_shaping_delay_ms(o_shaping_delay_ms),
    .o_com_level_code(o_com_level_code), .o_com_level_valid(o_com_level_valid),
    .o_com_split_range(o_com_split_range));

// [lbs_bias_regs_test.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module lbs_bias_regs_test;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] q; } lbs_row_t;
    // write value and expected read back, reserved bits cleared
    localparam lbs_row_t ROWS [10] = '{'{8'h05, 8'hff, 8'h1f}, '{8'h06, 8'hff, 8'h3f},
        '{8'h07, 8'hff, 8'h0f}, '{8'h08, 8'hff, 8'h07}, '{8'h09, 8'hff, 8'h0f}, '{8'h0a, 8'hff, 8'h03},
        '{8'h0b, 8'hff, 8'hff}, '{8'h0c, 8'ha5, 8'ha5}, '{8'h0d, 8'hff, 8'h00}, '{8'h04, 8'hff, 8'h00}};
    logic       clk = 1'b0, srst = 1'b1, ce = 1'b0, rsel = 1'b0, fix = 1'b0, cold = 1'b0;
    logic       wr, rd, hit, frq, nvl, cvl, spl;
    logic [7:0] addr, wd, rdat, ccode, q;
    logic [1:0] slw;
    logic [4:0] ss, rdl;
    logic [5:0] ncode, shp;
    logic [3:0] lrc;
    logic [2:0] thr;
    int         num_errors = 0, cmp_count = 0;
    lbs_host_model h (.i_clk_sys(clk), .i_rdata(rdat), .o_addr(addr), .o_wr(wr), .o_wdata(wd), .o_rd(rd));
    lbs_bias_regs i_dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_addr(addr), .i_wr(wr),
        .i_wdata(wd), .i_rd(rd), .i_com_range_sel(rsel), .i_com_fixed_setting(fix), .i_temp_cold(cold),
        .o_rdata(rdat), .o_hit(hit), .o_gate_high_switch_slew(slw), .o_gate_high_soft_start_ms(ss),
        .o_gate_high_switch_frequency(frq), .o_neg_gate_code(ncode), .o_neg_gate_valid(nvl),
        .o_logic_rail_code(lrc), .o_reset_threshold_code(thr), .o_reset_delay_ms(rdl),
        .o_shaping_delay_ms(shp), .o_com_level_code(ccode), .o_com_level_valid(cvl),
        .o_com_split_range(spl));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard, far beyond the roughly 125 cycles the sequence needs
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        ce   <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            h.rd(8'h05 + 8'(k), q);
            `CHK(q, 8'h00)
        end
        foreach (ROWS[i])
        begin
            h.wr(ROWS[i].a, ROWS[i].d);
            h.rd(ROWS[i].a, q);
            `CHK(q, ROWS[i].q)
        end
        `CHK({lrc, thr}, 7'h7f)
        // every code of the boost and shaping fields, four reset delay codes
        for (int k = 0; k < 4; k++)
        begin
            h.wr(8'h05, 8'(k * 21));
            h.wr(8'h09, 8'(k * 5));
            h.wr(8'h0a, 8'(k));
            `CHK({slw, frq}, 3'((k << 1) | (k & 1)))
            `CHK(ss, 5'(4 * (k + 1)))
            `CHK({rdl, shp}, {5'(10 * k), 6'(20 * k)})
            h.rd(8'h05, q);
            `CHK(q, 8'(k * 21) & 8'h1f)
        end
        // lowest valid negative rail code and the one below it
        for (int k = 0; k < 2; k++)
        begin
            h.wr(8'h06, 8'h14 + 8'(k));
            `CHK({ncode, nvl}, {6'h14 + 6'(k), k[0]})
        end
        h.wr(8'h0b, 8'h27);
        h.wr(8'h0c, 8'h28);
        `CHK({ccode, cvl}, 9'h04e)
        @(posedge clk);
        cold <= 1'b1;
        rsel <= 1'b1;
        @(posedge clk);
        #1 `CHK({ccode, cvl, spl}, 10'h0a3)
        @(posedge clk);
        fix <= 1'b1;
        ce  <= 1'b0;
        h.wr(8'h07, 8'h03);
        ce  <= 1'b1;
        #1 `CHK({ccode, lrc}, 12'h27f)
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        h.rd(8'h0c, q);
        `CHK(q, 8'h00)
        end_of_test();
    end
endmodule // lbs_bias_regs_test
